// File: tb/scan_line_timing_generator_bench.sv
// Purpose: Self-checking bench for the scan line timing generator
// Assumes: Sub-line tick shortened to two dots
// Notes: Per-cycle event counts are compared with values from the settings
`timescale 1ns/1ps
`default_nettype none
module scan_line_timing_generator_bench;
  localparam int TD = 2;
  localparam logic [31:0] A_SET = sltg_pkg::IDX_SCAN_SETUP;
  localparam logic [31:0] A_CYC = sltg_pkg::IDX_CYCLE_TICK_COUNT;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pixel_valid, sub_line_tick, tick_irq, cycle_start, err, ext_exp;
  wire logic [11:0] adc_int_data;
  wire logic [11:0] adc_ext_data;
  logic [6:0] scan_ctrl_pins;
  logic [11:0] pixel_data;
  logic [13:0] line_bytes;
  logic [31:0] rd, d;
  logic [5:0] ev;
  int miscompares, total_checks, n_cs, ps, dot;
  int seed = 74;
  int cnt[6];
  int snap[6];
  logic [31:0] idx_t[7] = '{A_SET, sltg_pkg::IDX_DOT_TIMING_CONTROL,
    sltg_pkg::IDX_VALID_PIXELS_PER_LINE, sltg_pkg::IDX_LINE_LEAD_IN_DELAY,
    sltg_pkg::IDX_START_PULSE_EDGES, sltg_pkg::IDX_START_PULSE_CONFIG, A_CYC};
  logic [31:0] msk_t[7] = '{32'hff7e, 32'hff, 32'h1fff, 32'h1fff, 32'hff, 32'hffff, 32'h1f00};
  sltg_top #(.TICK_DOTS(TD)) sltg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_int_data(adc_int_data),
    .adc_ext_data(adc_ext_data), .scan_ctrl_pins(scan_ctrl_pins), .pixel_data(pixel_data),
    .pixel_valid(pixel_valid), .sub_line_tick(sub_line_tick), .tick_irq(tick_irq),
    .cycle_start(cycle_start), .line_bytes(line_bytes));
  sltg_sensor_model sltg_sensor_model_i (.pclk(pclk), .presetn(presetn),
    .start_pin(scan_ctrl_pins[0]), .adc_int_data(adc_int_data), .adc_ext_data(adc_ext_data));
  always #50 pclk = ~pclk;
  // ==========================================================
  // Checking and bus tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= idx << 2;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_cs;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (cycle_start !== 1'b1 && n < 2000);
    if (cycle_start !== 1'b1) begin
      miscompares++;
      conclude();
    end
  endtask
  // ==========================================================
  // Per-cycle event counters and pixel data check
  assign ev = {scan_ctrl_pins[6], scan_ctrl_pins[0], pixel_valid, tick_irq, sub_line_tick, 1'b1};
  always @(posedge pclk) begin
    for (int k = 0; k < 6; k++) begin
      if (cycle_start === 1'b1) begin
        snap[k] <= cnt[k];
        cnt[k] <= int'(ev[k]);
      end else begin
        cnt[k] <= cnt[k] + int'(ev[k]);
      end
    end
    if (cycle_start === 1'b1) begin
      n_cs <= n_cs + 1;
    end
    if (pixel_valid === 1'b1) begin
      check("pixel_data", pixel_data, ext_exp ? adc_ext_data : adc_int_data);
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    ext_exp = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, idx_t[i], 32'h0);
      check("reset_value", rd, 32'h0);
      d = $random(seed) & msk_t[i];
      apb(1'b1, idx_t[i], d | (i == 6 ? 32'h1f : 32'h0));
      apb(1'b0, idx_t[i], 32'h0);
      check("read_back", rd, d);
    end
    apb(1'b0, 32'h01ff8891, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    apb(1'b1, A_SET, 32'h7f3e);
    repeat (3) @(posedge pclk);
    check("pins_inverted", {25'h0, scan_ctrl_pins}, 32'h7f);
    apb(1'b1, A_SET, 32'h7f00);
    repeat (3) @(posedge pclk);
    check("pins_unselected", {25'h0, scan_ctrl_pins}, 32'h03);
    for (int i = 0; i < 2; i++) begin
      ps = $random(seed) & 1;
      // Long dots keep converter changes clear of the first valid pixel
      dot = 4 * (ps + 1);
      apb(1'b1, sltg_pkg::IDX_DOT_TIMING_CONTROL, (ps << 4) | 3);
      apb(1'b1, sltg_pkg::IDX_VALID_PIXELS_PER_LINE, 32'h3);
      apb(1'b1, sltg_pkg::IDX_LINE_LEAD_IN_DELAY, 32'h1);
      apb(1'b1, sltg_pkg::IDX_START_PULSE_EDGES, 32'h0);
      apb(1'b1, sltg_pkg::IDX_START_PULSE_CONFIG, 32'h11 | (i << 15) | (i << 9));
      apb(1'b1, A_CYC, 32'h0102);
      ext_exp = i[0];
      apb(1'b1, A_SET, (i << 15) | (i << 6) | 32'h20 | 1);
      check("line_bytes", {18'h0, line_bytes}, 32'h6);
      repeat (3) wait_cs();
      @(posedge pclk);
      check("cycle_clocks", snap[0], 3 * TD * dot);
      check("ticks_per_cycle", snap[1], 3);
      check("irq_per_cycle", snap[2], i);
      check("pixels_per_cycle", snap[3], 3);
      check("start_width", snap[4], 2 * dot);
      check("quiet_pin6", snap[5], 3 - i);
      apb(1'b0, A_CYC, 32'h0);
      check("irq_position", rd[12:8], 32'h1);
      check("live_count_range", {31'h0, rd[4:0] <= 5'h2}, 32'h1);
      apb(1'b1, A_SET, 32'h0);
      // Pulses launched before the stop must land first
      repeat (2) @(posedge pclk);
      d = n_cs;
      repeat (40) @(posedge pclk);
      check("stopped_cycles", n_cs, d);
    end
    conclude();
  end
endmodule
`default_nettype wire

// File: tb/sltg_sensor_model.sv
// Purpose: Image sensor and converter pair seen by the timing generator
// Assumes: Start pulse pin not inverted while scanning
// Notes: External converter changes on the falling edge, unrelated to sampling
`timescale 1ns/1ps
`default_nettype none
module sltg_sensor_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start_pin,
  output logic [11:0] adc_int_data,
  output logic [11:0] adc_ext_data
);
  // ==========================================================
  // New line level at each start pulse
  logic start_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_d <= 1'b0;
      adc_int_data <= 12'h0a5;
    end else begin
      start_d <= start_pin;
      if (start_pin && !start_d) begin
        adc_int_data <= adc_int_data + 12'h111;
      end
    end
  end
  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_ext_data <= 12'h35c;
    end else if (start_pin && !start_d) begin
      adc_ext_data <= ~adc_ext_data;
    end
  end
endmodule
`default_nettype wire

// File: tb/sltg_sva.sv
// Purpose: Port-level checks for the scan line timing generator
// Assumes: Zero wait-state APB; one clock domain
// Notes: A few register fields are shadowed from completed APB writes
`timescale 1ns/1ps
`default_nettype none
module sltg_sva #(
  parameter int TICK_DOTS = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] adc_int_data,
  input wire logic [11:0] adc_ext_data,
  input wire logic [6:0] scan_ctrl_pins,
  input wire logic [11:0] pixel_data,
  input wire logic pixel_valid,
  input wire logic sub_line_tick,
  input wire logic tick_irq,
  input wire logic cycle_start,
  input wire logic [13:0] line_bytes
);
  // ==========================================================
  // Register shadows
  logic wr_ok;
  logic run_q;
  logic irq_q;
  logic [4:0] sel_q;
  logic [12:0] vpc_q;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      irq_q <= 1'b0;
      sel_q <= 5'h00;
    end else if (wr_ok && paddr == (sltg_pkg::IDX_SCAN_SETUP << 2)) begin
      run_q <= pwdata[0];
      irq_q <= pwdata[15];
      sel_q <= pwdata[5:1];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vpc_q <= 13'h0000;
    end else if (wr_ok && paddr == (sltg_pkg::IDX_VALID_PIXELS_PER_LINE << 2)) begin
      vpc_q <= pwdata[12:0];
    end
  end
  // ==========================================================
  // Assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_once: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_read_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  chk_irq_gated: assert property (tick_irq |-> $past(run_q && irq_q))
    else $error("tick interrupt without enables");
  chk_idle_quiet: assert property (
    !run_q && !$past(run_q) |-> !(cycle_start || sub_line_tick || tick_irq || pixel_valid))
    else $error("timing pulse while stopped");
  chk_cycle_pulse: assert property (cycle_start |=> !cycle_start [*3])
    else $error("cycle start too close");
  chk_tick_gap: assert property (sub_line_tick |=> !sub_line_tick [*3])
    else $error("sub line ticks too close");
  chk_pixel_pulse: assert property (pixel_valid |=> !pixel_valid)
    else $error("pixel valid wider than one cycle");
  chk_pin_select: assert property (
    (scan_ctrl_pins[6:2] & ~(sel_q | $past(sel_q))) == 5'h00)
    else $error("unselected control pin driven");
  chk_line_bytes: assert property (vpc_q == $past(vpc_q) |-> line_bytes == {vpc_q, 1'b0})
    else $error("line byte count wrong");
endmodule
bind sltg_top sltg_sva #(.TICK_DOTS(TICK_DOTS)) sltg_sva_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_int_data(adc_int_data),
  .adc_ext_data(adc_ext_data), .scan_ctrl_pins(scan_ctrl_pins), .pixel_data(pixel_data),
  .pixel_valid(pixel_valid), .sub_line_tick(sub_line_tick), .tick_irq(tick_irq),
  .cycle_start(cycle_start), .line_bytes(line_bytes));
`default_nettype wire

// File: verilog/sltg_pkg.sv
// Purpose: Constants and types for the scan line timing generator
// Assumes: APB with 32-bit data; register index times four is the byte address
// Notes: Registers are 16 bits wide, upper bits read as zero
`default_nettype none
package sltg_pkg;

  // ==========================================================
  // Register indexes
  localparam logic [31:0] IDX_CYCLE_TICK_COUNT = 32'h01ff8890;
  localparam logic [31:0] IDX_SCAN_SETUP = 32'h01ff8893;
  localparam logic [31:0] IDX_DOT_TIMING_CONTROL = 32'h01ff8894;
  localparam logic [31:0] IDX_VALID_PIXELS_PER_LINE = 32'h01ff8896;
  localparam logic [31:0] IDX_LINE_LEAD_IN_DELAY = 32'h01ff8898;
  localparam logic [31:0] IDX_START_PULSE_EDGES = 32'h01ff889b;
  localparam logic [31:0] IDX_START_PULSE_CONFIG = 32'h01ff889d;

  // ==========================================================
  // Field positions
  localparam int SETUP_IRQ_EN_BIT = 15;
  localparam int SETUP_INV_LSB = 8;
  localparam int SETUP_EXT_ADC_BIT = 6;
  localparam int SETUP_PIN_SEL_LSB = 1;
  localparam int SETUP_RUN_BIT = 0;
  localparam int CYCLE_IRQ_LOC_LSB = 8;
  localparam int DOT_PRESCALE_LSB = 4;
  localparam int EDGE_FALL_LSB = 4;
  localparam int CFG_QUIET_EN_LSB = 13;
  localparam int CFG_QUIET_LSB = 8;
  localparam int CFG_OFFSET_LSB = 4;

  // ==========================================================
  // Reset values and counts
  localparam logic [15:0] RESET_REG = 16'h0000;
  localparam logic [13:0] PIXEL_MAX = 14'h3fff;
  localparam int TICK_DOTS_DEFAULT = 64;

  typedef struct packed {
    logic irq_en;
    logic [6:0] invert;
    logic unused7;
    logic ext_adc;
    logic [4:0] pin_sel;
    logic run;
  } sltg_setup_t;

  typedef struct packed {
    logic [6:0] ctrl;
    logic start;
  } sltg_ctrl_t;

endpackage
`default_nettype wire

// File: verilog/sltg_top.sv
// Purpose: Scan line timing generator with APB register access
// Assumes: pclk at 10 MHz; external converter data is asynchronous
// Notes: Zero wait-state APB; pready and read data rise in the access phase
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: Tick-count field sets one to thirty-two sub-line ticks per scan cycle.
// R2: Scan cycle begins when tick counter wraps from maximum to zero.
// R3: Reading tick-count field returns live tick count, not programmed value.
// R4: Software programs tick-count register before setting the run enable.
// R5: Tick interrupt at programmed position only when interrupt and run enabled.
// R6: Seven invert bits flip polarity of matching control signals.
// R7: Converter select: clear takes on-chip converter, set takes external one.
// R8: Five pin-select bits choose which control signals reach the pins.
// R9: All timing logic idle unless the run enable bit is set.
// R10: Prescaled clock period is prescale field plus one base periods.
// R11: Dot period is dot length field plus one prescaled periods.
// R12: Software never programs dot length field with zero.
// R13: Valid pixel count per line; line stores twice that many bytes.
// R14: Pixel counter is fourteen bits and saturates at maximum.
// R15: Lead-in delay skips that many dots from start pulse before valid data.
// R16: Lead-in time is delay plus one times the dot period.
// R17: Two nibbles place start pulse trailing and leading edges.
// R18: Start edge positions count prescaled periods from each dot start.
// R19: Pixel counter clears at cycle start, advances each dot while running.
// R20: Interrupt position double-buffered at cycle start, matched against tick count.
// R21: Quiet window freezes enabled control signals six to four during start.
// R22: Offset field delays start pulse by that many pixel periods.
// R23: Start pulse lasts length field plus one pixel periods.
module sltg_top #(
  parameter int TICK_DOTS = sltg_pkg::TICK_DOTS_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] adc_int_data,
  input wire logic [11:0] adc_ext_data,
  output logic [6:0] scan_ctrl_pins,
  output logic [11:0] pixel_data,
  output logic pixel_valid,
  output logic sub_line_tick,
  output logic tick_irq,
  output logic cycle_start,
  output logic [13:0] line_bytes
);

  // ==========================================================
  // Registers
  sltg_pkg::sltg_setup_t scan_setup;
  logic [15:0] cycle_tick_count;
  logic [15:0] dot_timing_control;
  logic [15:0] valid_pixels_per_line;
  logic [15:0] line_lead_in_delay;
  logic [15:0] start_pulse_edges;
  logic [15:0] start_pulse_config;

  // ==========================================================
  // Timing state
  logic [3:0] pre_cnt;
  logic [3:0] dot_pos;
  logic [15:0] tick_dot_cnt;
  logic [4:0] tick_cnt;
  logic [4:0] ticks_per_cycle;
  logic [4:0] irq_loc_buf;
  logic [13:0] pixel_cnt;
  logic [4:0] quiet_cnt;
  logic run_d;
  sltg_pkg::sltg_ctrl_t raw;
  sltg_pkg::sltg_ctrl_t held;
  logic [11:0] ext_s1;
  logic [11:0] ext_s2;
  logic [11:0] ext_s3;
  logic [11:0] ext_data;

  function automatic logic sel_match(input logic [31:0] addr, input logic [31:0] idx);
    sel_match = (addr == {idx[29:0], 2'b00});
  endfunction

  // ==========================================================
  // Combinational timing terms
  logic run;
  logic [3:0] prescale;
  logic [3:0] dot_length;
  logic pre_tick;
  logic dot_end;
  logic tick_end;
  logic wrap;
  logic first_cycle;
  logic new_cycle;
  logic [4:0] next_tick_cnt;
  logic [13:0] dots_from_start;
  logic [13:0] offset_dots;
  logic [13:0] lead_end;
  logic [13:0] valid_end;
  logic in_start_win;
  logic start_level;
  logic in_valid;
  logic start_rise;

  assign run = scan_setup.run;
  assign prescale = dot_timing_control[sltg_pkg::DOT_PRESCALE_LSB +: 4];
  assign dot_length = dot_timing_control[3:0];
  assign pre_tick = run && (pre_cnt == prescale); // [R10]
  assign dot_end = pre_tick && (dot_pos == dot_length); // [R11]
  assign tick_end = dot_end && (tick_dot_cnt == 16'(TICK_DOTS - 1));
  assign wrap = tick_end && (tick_cnt == ticks_per_cycle); // [R2]
  assign first_cycle = run && !run_d;
  assign new_cycle = wrap || first_cycle;
  assign next_tick_cnt = wrap ? 5'h00 : tick_cnt + 5'h01;
  assign offset_dots = {10'h000, start_pulse_config[sltg_pkg::CFG_OFFSET_LSB +: 4]};
  assign dots_from_start = pixel_cnt - offset_dots;
  // Valid dots follow the delay plus one skipped dots
  assign lead_end = line_lead_in_delay[12:0] + 14'h0001; // [R15] [R16]
  assign valid_end = lead_end + {1'b0, valid_pixels_per_line[12:0]}; // [R13]
  assign in_start_win = (pixel_cnt >= offset_dots) &&
                        (dots_from_start <= {10'h000, start_pulse_config[3:0]}); // [R22] [R23]
  assign start_level = in_start_win && (dot_pos >= start_pulse_edges[3:0]) &&
                       ((start_pulse_edges[7:4] <= start_pulse_edges[3:0]) ||
                        (dot_pos < start_pulse_edges[sltg_pkg::EDGE_FALL_LSB +: 4])); // [R17] [R18]
  assign in_valid = (pixel_cnt >= offset_dots) && (dots_from_start >= lead_end) &&
                    (dots_from_start < valid_end);
  assign start_rise = in_start_win && (pixel_cnt == offset_dots) && (dot_pos == 4'h0) &&
                      (pre_cnt == 4'h0);

  // ==========================================================
  // APB slave
  logic wr_en;
  logic rd_hit;
  logic [15:0] rd_val;

  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 16'h0000;
    if (sel_match(paddr, sltg_pkg::IDX_SCAN_SETUP)) begin
      rd_val = scan_setup;
    end else if (sel_match(paddr, sltg_pkg::IDX_CYCLE_TICK_COUNT)) begin
      rd_val = {3'h0, cycle_tick_count[12:8], 3'h0, tick_cnt}; // [R3]
    end else if (sel_match(paddr, sltg_pkg::IDX_DOT_TIMING_CONTROL)) begin
      rd_val = {8'h00, dot_timing_control[7:0]};
    end else if (sel_match(paddr, sltg_pkg::IDX_VALID_PIXELS_PER_LINE)) begin
      rd_val = {3'h0, valid_pixels_per_line[12:0]};
    end else if (sel_match(paddr, sltg_pkg::IDX_LINE_LEAD_IN_DELAY)) begin
      rd_val = {3'h0, line_lead_in_delay[12:0]};
    end else if (sel_match(paddr, sltg_pkg::IDX_START_PULSE_EDGES)) begin
      rd_val = {8'h00, start_pulse_edges[7:0]};
    end else if (sel_match(paddr, sltg_pkg::IDX_START_PULSE_CONFIG)) begin
      rd_val = start_pulse_config;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !rd_hit;
      prdata <= (psel && !penable && !pwrite) ? {16'h0000, rd_val} : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_setup <= sltg_pkg::RESET_REG;
      cycle_tick_count <= sltg_pkg::RESET_REG;
      dot_timing_control <= sltg_pkg::RESET_REG;
      valid_pixels_per_line <= sltg_pkg::RESET_REG;
      line_lead_in_delay <= sltg_pkg::RESET_REG;
      start_pulse_edges <= sltg_pkg::RESET_REG;
      start_pulse_config <= sltg_pkg::RESET_REG;
    end else if (wr_en) begin
      if (sel_match(paddr, sltg_pkg::IDX_SCAN_SETUP)) begin
        scan_setup <= {pwdata[15:8], 1'b0, pwdata[6:0]};
      end
      if (sel_match(paddr, sltg_pkg::IDX_CYCLE_TICK_COUNT)) begin
        cycle_tick_count <= {3'h0, pwdata[12:8], 3'h0, pwdata[4:0]};
      end
      if (sel_match(paddr, sltg_pkg::IDX_DOT_TIMING_CONTROL)) begin
        dot_timing_control <= {8'h00, pwdata[7:0]};
      end
      if (sel_match(paddr, sltg_pkg::IDX_VALID_PIXELS_PER_LINE)) begin
        valid_pixels_per_line <= {3'h0, pwdata[12:0]};
      end
      if (sel_match(paddr, sltg_pkg::IDX_LINE_LEAD_IN_DELAY)) begin
        line_lead_in_delay <= {3'h0, pwdata[12:0]};
      end
      if (sel_match(paddr, sltg_pkg::IDX_START_PULSE_EDGES)) begin
        start_pulse_edges <= {8'h00, pwdata[7:0]};
      end
      if (sel_match(paddr, sltg_pkg::IDX_START_PULSE_CONFIG)) begin
        start_pulse_config <= pwdata[15:0];
      end
    end
  end

  // ==========================================================
  // Prescaler and dot period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 4'h0;
      dot_pos <= 4'h0;
      run_d <= 1'b0;
    end else begin
      run_d <= run;
      if (!run || first_cycle) begin // [R9]
        pre_cnt <= 4'h0;
        dot_pos <= 4'h0;
      end else if (pre_tick) begin
        pre_cnt <= 4'h0;
        dot_pos <= (dot_pos == dot_length) ? 4'h0 : dot_pos + 4'h1; // [R11] [R12]
      end else begin
        pre_cnt <= pre_cnt + 4'h1; // [R10]
      end
    end
  end

  // ==========================================================
  // Sub-line ticks and scan cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_dot_cnt <= 16'h0000;
      tick_cnt <= 5'h00;
      ticks_per_cycle <= 5'h00;
      irq_loc_buf <= 5'h00;
      sub_line_tick <= 1'b0;
      tick_irq <= 1'b0;
      cycle_start <= 1'b0;
    end else begin
      sub_line_tick <= tick_end;
      cycle_start <= new_cycle;
      tick_irq <= 1'b0;
      if (!run) begin // [R9]
        tick_dot_cnt <= 16'h0000;
        tick_cnt <= 5'h00;
      end else if (first_cycle) begin
        tick_dot_cnt <= 16'h0000;
        tick_cnt <= 5'h00;
        ticks_per_cycle <= cycle_tick_count[4:0]; // [R4] [R1]
        irq_loc_buf <= cycle_tick_count[sltg_pkg::CYCLE_IRQ_LOC_LSB +: 5]; // [R20]
        tick_irq <= scan_setup.irq_en &&
                    (cycle_tick_count[sltg_pkg::CYCLE_IRQ_LOC_LSB +: 5] == 5'h00); // [R5]
      end else if (dot_end) begin
        tick_dot_cnt <= tick_end ? 16'h0000 : tick_dot_cnt + 16'h0001;
        if (tick_end) begin
          tick_cnt <= next_tick_cnt; // [R1] [R2]
          if (wrap) begin
            ticks_per_cycle <= cycle_tick_count[4:0];
            irq_loc_buf <= cycle_tick_count[sltg_pkg::CYCLE_IRQ_LOC_LSB +: 5]; // [R20]
            tick_irq <= scan_setup.irq_en &&
                        (cycle_tick_count[sltg_pkg::CYCLE_IRQ_LOC_LSB +: 5] == 5'h00); // [R5]
          end else begin
            tick_irq <= scan_setup.irq_en && (next_tick_cnt == irq_loc_buf); // [R5] [R20]
          end
        end
      end
    end
  end

  // ==========================================================
  // Pixel counter and quiet window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pixel_cnt <= 14'h0000;
    end else if (!run || new_cycle) begin
      pixel_cnt <= 14'h0000; // [R19]
    end else if (dot_end && pixel_cnt != sltg_pkg::PIXEL_MAX) begin
      pixel_cnt <= pixel_cnt + 14'h0001; // [R14] [R19]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_cnt <= 5'h00;
    end else if (!run || !in_start_win) begin
      quiet_cnt <= 5'h00;
    end else if (start_rise) begin
      quiet_cnt <= start_pulse_config[sltg_pkg::CFG_QUIET_LSB +: 5]; // [R21]
    end else if (dot_end && quiet_cnt != 5'h00) begin
      quiet_cnt <= quiet_cnt - 5'h01;
    end
  end

  // ==========================================================
  // Control signal generation
  always_comb begin
    raw.start = start_level && run;
    raw.ctrl[0] = run && (dot_pos == 4'h0);
    raw.ctrl[1] = run && in_valid;
    raw.ctrl[2] = new_cycle;
    raw.ctrl[3] = run && (pre_cnt == 4'h0);
    raw.ctrl[4] = run && (dot_pos <= {1'b0, dot_length[3:1]});
    raw.ctrl[5] = dot_end;
    raw.ctrl[6] = tick_end;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= '0;
    end else begin
      held.start <= raw.start;
      held.ctrl[3:0] <= raw.ctrl[3:0];
      for (int i = 4; i < 7; i++) begin
        if (!(start_pulse_config[sltg_pkg::CFG_QUIET_EN_LSB + i - 4] &&
              quiet_cnt != 5'h00)) begin
          held.ctrl[i] <= raw.ctrl[i]; // [R21]
        end
      end
    end
  end

  // Index zero carries the start pulse; pins two to six are selectable
  logic [6:0] ctrl_sig;
  logic [6:0] ctrl_inv;
  assign ctrl_sig = {held.ctrl[6:2], held.ctrl[0], held.start};
  assign ctrl_inv = ctrl_sig ^ scan_setup.invert; // [R6]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_ctrl_pins <= 7'h00;
    end else begin
      scan_ctrl_pins <= {ctrl_inv[6:2] & scan_setup.pin_sel, ctrl_inv[1:0]}; // [R8]
    end
  end

  // ==========================================================
  // Converter data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1 <= 12'h000;
      ext_s2 <= 12'h000;
      ext_s3 <= 12'h000;
      ext_data <= 12'h000;
    end else begin
      ext_s1 <= adc_ext_data;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      if (ext_s2 == ext_s3) begin
        ext_data <= ext_s3;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pixel_data <= 12'h000;
      pixel_valid <= 1'b0;
      line_bytes <= 14'h0000;
    end else begin
      line_bytes <= {valid_pixels_per_line[12:0], 1'b0}; // [R13]
      pixel_valid <= dot_end && in_valid; // [R15]
      if (dot_end && in_valid) begin
        pixel_data <= scan_setup.ext_adc ? ext_data : adc_int_data; // [R7]
      end
    end
  end

endmodule
`default_nettype wire
